// File: hw/sirq_top.sv
`default_nettype none

// ==========================================================
// Interrupt enable and pin routing for the acceleration events
module sirq_top #(
	parameter int unsigned SRC_W = sirq_pkg::SRC_COUNT
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire sirq_pkg::sirq_reg_req_t reg_req,
	output logic [sirq_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_hit,
	input wire sirq_pkg::sirq_src_t src_flags,
	input wire logic irq_active_high,
	output logic irq_pin_first,
	output logic irq_pin_second,
	output logic [SRC_W-1:0] pending_first,
	output logic [SRC_W-1:0] pending_second
);

	// ==========================================================
	// Address decoding
	// Used by both the write path and the read path
	function automatic logic addr_is(
		input logic [sirq_pkg::ADDR_W-1:0] addr,
		input logic [sirq_pkg::ADDR_W-1:0] target
	);
		addr_is = (addr == target);
	endfunction

	logic sel_enable;
	logic sel_routing;
	logic wr_enable;
	logic wr_routing;
	logic any_sel;

	// Only the two documented offsets respond here; the magnetic enables
	// and the polarity bit belong to other registers
	assign sel_enable = addr_is(reg_req.addr, sirq_pkg::ADDR_SOURCE_ENABLE);
	assign sel_routing = addr_is(reg_req.addr, sirq_pkg::ADDR_PIN_ROUTING);
	assign any_sel = sel_enable | sel_routing;
	assign wr_enable = reg_req.wr & sel_enable;
	assign wr_routing = reg_req.wr & sel_routing;

	// ==========================================================
	// Registers
	logic [SRC_W-1:0] source_enable_q;
	logic [SRC_W-1:0] source_enable_d;
	logic [SRC_W-1:0] pin_routing_q;
	logic [SRC_W-1:0] pin_routing_d;

	// Full-byte writes; every bit is read/write
	assign source_enable_d = wr_enable ? reg_req.wdata[SRC_W-1:0] : source_enable_q;
	assign pin_routing_d = wr_routing ? reg_req.wdata[SRC_W-1:0] : pin_routing_q;

	// Both registers clear to zero: all sources off, all routed second pin
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			source_enable_q <= sirq_pkg::RESET_SOURCE_ENABLE[SRC_W-1:0];
			pin_routing_q <= sirq_pkg::RESET_PIN_ROUTING[SRC_W-1:0];
		end else begin
			source_enable_q <= source_enable_d;
			pin_routing_q <= pin_routing_d;
		end
	end

	// ==========================================================
	// Read path
	logic [sirq_pkg::DATA_W-1:0] rdata_sel;
	logic [sirq_pkg::DATA_W-1:0] rdata_q;
	logic [sirq_pkg::DATA_W-1:0] rdata_d;
	logic hit_q;
	logic hit_d;

	// Unmapped reads return zero rather than stale data
	assign rdata_sel = sel_enable ? sirq_pkg::DATA_W'(source_enable_q) :
		sel_routing ? sirq_pkg::DATA_W'(pin_routing_q) :
		sirq_pkg::READ_UNMAPPED;
	assign rdata_d = reg_req.rd ? rdata_sel : rdata_q;
	assign hit_d = (reg_req.rd | reg_req.wr) & any_sel;

	// Read data held until the next read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= sirq_pkg::READ_UNMAPPED;
			hit_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			hit_q <= hit_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_hit = hit_q;

	// ==========================================================
	// Source flags in register bit order
	logic [SRC_W-1:0] flags_vec;

	// Explicit placement keeps the struct order tied to the bit constants
	assign flags_vec[sirq_pkg::BIT_SLEEP] = src_flags.sleep_wake;
	assign flags_vec[sirq_pkg::BIT_FIFO] = src_flags.fifo;
	assign flags_vec[sirq_pkg::BIT_TRANSIENT] = src_flags.transient;
	assign flags_vec[sirq_pkg::BIT_ORIENT] = src_flags.orient;
	assign flags_vec[sirq_pkg::BIT_PULSE] = src_flags.pulse;
	assign flags_vec[sirq_pkg::BIT_FREEFALL] = src_flags.freefall;
	assign flags_vec[sirq_pkg::BIT_VECM] = src_flags.vecm;
	assign flags_vec[sirq_pkg::BIT_DATA_READY] = src_flags.data_ready;

	// ==========================================================
	// Pin routers
	// Each enabled source lands on exactly one pin, because the two
	// routers take complementary routing codes from the same bit
	logic [sirq_pkg::PIN_COUNT-1:0] pin_level;
	logic [SRC_W-1:0] pin_pending [sirq_pkg::PIN_COUNT];

	genvar p;
	generate
		for (p = 0; p < sirq_pkg::PIN_COUNT; p++) begin : g_pin
			sirq_pin_route #(
				.WIDTH(SRC_W),
				.SELECT_CODE((p == sirq_pkg::PIN_IDX_FIRST) ?
					sirq_pkg::ROUTE_TO_FIRST : sirq_pkg::ROUTE_TO_SECOND)
			) u_route (
				.clock(clock),
				.reset_n(reset_n),
				.flags(flags_vec),
				.enable(source_enable_q),
				.route(pin_routing_q),
				.active_high(irq_active_high),
				.pin(pin_level[p]),
				.pending(pin_pending[p])
			);
		end
	endgenerate

	// ==========================================================
	// Outputs
	assign irq_pin_first = pin_level[sirq_pkg::PIN_IDX_FIRST];
	assign irq_pin_second = pin_level[sirq_pkg::PIN_IDX_SECOND];
	assign pending_first = pin_pending[sirq_pkg::PIN_IDX_FIRST];
	assign pending_second = pin_pending[sirq_pkg::PIN_IDX_SECOND];

endmodule

`default_nettype wire

// File: common/sirq_pkg.sv
`default_nettype none

package sirq_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned SRC_COUNT = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PIN_COUNT = 2;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_SOURCE_ENABLE = 8'h2D;
	localparam logic [7:0] ADDR_PIN_ROUTING = 8'h2E;
	localparam logic [7:0] RESET_SOURCE_ENABLE = 8'h00;
	localparam logic [7:0] RESET_PIN_ROUTING = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// ==========================================================
	// Source bit positions, shared by enable and routing
	localparam int unsigned BIT_SLEEP = 7;
	localparam int unsigned BIT_FIFO = 6;
	localparam int unsigned BIT_TRANSIENT = 5;
	localparam int unsigned BIT_ORIENT = 4;
	localparam int unsigned BIT_PULSE = 3;
	localparam int unsigned BIT_FREEFALL = 2;
	localparam int unsigned BIT_VECM = 1;
	localparam int unsigned BIT_DATA_READY = 0;

	// ==========================================================
	// Routing and pin encodings
	localparam logic ROUTE_TO_SECOND = 1'b0;
	localparam logic ROUTE_TO_FIRST = 1'b1;
	localparam int unsigned PIN_IDX_FIRST = 0;
	localparam int unsigned PIN_IDX_SECOND = 1;
	localparam logic POLARITY_ACTIVE_LOW = 1'b0;
	// Pin level during reset: deasserted for the default active-low polarity
	localparam logic PIN_RESET_LEVEL = 1'b1;

	// ==========================================================
	// Event flags from the detectors, packed in register bit order
	typedef struct packed {
		logic sleep_wake;
		logic fifo;
		logic transient;
		logic orient;
		logic pulse;
		logic freefall;
		logic vecm;
		logic data_ready;
	} sirq_src_t;

	// Register access request
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} sirq_reg_req_t;

endpackage

`default_nettype wire

// File: hw/sirq_pin_route.sv
`default_nettype none

// ==========================================================
// One interrupt pin: collects enabled sources routed here
module sirq_pin_route #(
	parameter int unsigned WIDTH = 8,
	parameter logic SELECT_CODE = 1'b1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] flags,
	input wire logic [WIDTH-1:0] enable,
	input wire logic [WIDTH-1:0] route,
	input wire logic active_high,
	output logic pin,
	output logic [WIDTH-1:0] pending
);

	logic [WIDTH-1:0] route_match;
	logic [WIDTH-1:0] pending_d;
	logic hit;
	logic pin_d;
	logic pin_q;
	logic [WIDTH-1:0] pending_q;

	// Source belongs to this pin when its routing bit equals our code
	assign route_match = (SELECT_CODE == 1'b1) ? route : ~route;
	assign pending_d = flags & enable & route_match;
	assign hit = |pending_d;
	// Polarity applied last so both pins always agree on it
	assign pin_d = active_high ? hit : ~hit;

	// Registered pin and pending view
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_q <= sirq_pkg::PIN_RESET_LEVEL;
			pending_q <= '0;
		end else begin
			pin_q <= pin_d;
			pending_q <= pending_d;
		end
	end

	assign pin = pin_q;
	assign pending = pending_q;

endmodule

`default_nettype wire

// File: dv/sirq_props.sv
`default_nettype none
// ==========
// Port checks; register state mirrored from writes
module sirq_props #(
	parameter int unsigned SRC_W = 8
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire sirq_pkg::sirq_reg_req_t reg_req,
	input wire logic [sirq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic reg_hit,
	input wire sirq_pkg::sirq_src_t src_flags,
	input wire logic irq_active_high,
	input wire logic irq_pin_first,
	input wire logic irq_pin_second,
	input wire logic [SRC_W-1:0] pending_first,
	input wire logic [SRC_W-1:0] pending_second
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] en_q;
	logic [7:0] rt_q;
	wire en_sel = reg_req.addr == sirq_pkg::ADDR_SOURCE_ENABLE;
	wire rt_sel = reg_req.addr == sirq_pkg::ADDR_PIN_ROUTING;
	wire [7:0] live = src_flags & en_q;
	// Expected sources per pin, named so that $past sees a plain signal
	wire [7:0] live_first = live & rt_q;
	wire [7:0] live_second = live & ~rt_q;
	// Mirror lands on the write edge, so pins lag a write by two edges
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			en_q <= 8'h00;
			rt_q <= 8'h00;
		end else if (reg_req.wr) begin
			en_q <= en_sel ? reg_req.wdata : en_q;
			rt_q <= rt_sel ? reg_req.wdata : rt_q;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_en_read_back: assert property (reg_req.rd && en_sel |=> reg_rdata == $past(en_q))
		else $error("enable readback wrong");
	a_rt_read_back: assert property (reg_req.rd && rt_sel |=> reg_rdata == $past(rt_q))
		else $error("routing readback wrong");
	a_unmapped_read: assert property (reg_req.rd && !en_sel && !rt_sel |=>
		reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read answered");
	a_mapped_hit: assert property ((reg_req.rd || reg_req.wr) && (en_sel || rt_sel) |=> reg_hit)
		else $error("hit missing");
	a_pend_first: assert property (pending_first == $past(live_first))
		else $error("first pin sources wrong");
	a_pend_second: assert property (pending_second == $past(live_second))
		else $error("second pin sources wrong");
	a_one_pin_only: assert property (!(|(pending_first & pending_second)))
		else $error("source on both pins");
	a_first_level: assert property (irq_pin_first == ((|pending_first) ~^ $past(irq_active_high)))
		else $error("first pin level wrong");
	a_second_level: assert property (irq_pin_second == ((|pending_second) ~^ $past(irq_active_high)))
		else $error("second pin level wrong");
	c_pins_differ: cover property (irq_pin_first != irq_pin_second);
	c_hit: cover property (reg_hit);
	c_unmapped: cover property (reg_req.rd && !en_sel && !rt_sel);
endmodule
bind sirq_top sirq_props #(.SRC_W(SRC_W)) i_props (.clock(clock), .reset_n(reset_n),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .src_flags(src_flags),
	.irq_active_high(irq_active_high), .irq_pin_first(irq_pin_first),
	.irq_pin_second(irq_pin_second), .pending_first(pending_first),
	.pending_second(pending_second));
`default_nettype wire

// File: dv/sirq_host_model.sv
`default_nettype none
// ==========
// Host side: turns pin levels into asserted requests
module sirq_host_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic active_high,
	input wire logic pin_first,
	input wire logic pin_second,
	output logic [1:0] seen_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sampled per edge; the host cannot see glitches between edges
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			seen_q <= 2'h0;
		end else begin
			seen_q <= {pin_second, pin_first} ~^ {2{active_high}};
		end
	end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
// ==========
// Bench: driver notes results, monitor matches them
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	sirq_pkg::sirq_reg_req_t reg_req = '0;
	sirq_pkg::sirq_src_t src_flags = '0;
	logic irq_active_high = 1'b0;
	logic probe = 1'b0;
	logic rd_d = 1'b0;
	logic op_d = 1'b0;
	logic hq[$];
	logic pr_d = 1'b0;
	logic [7:0] reg_rdata, pending_first, pending_second;
	logic reg_hit, irq_pin_first, irq_pin_second;
	logic [1:0] seen_q;
	logic [17:0] iq[$];
	logic [7:0] rq[$];
	int err_total = 0;
	int cmp_count = 0;
	int seed = 32'hE762F11F;
	sirq_top i_dut (.clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .src_flags(src_flags), .irq_active_high(irq_active_high),
		.irq_pin_first(irq_pin_first), .irq_pin_second(irq_pin_second),
		.pending_first(pending_first), .pending_second(pending_second));
	sirq_host_model i_host (.clock(clock), .reset_n(reset_n), .active_high(irq_active_high),
		.pin_first(irq_pin_first), .pin_second(irq_pin_second), .seen_q(seen_q));
	task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One-cycle strobe; reads note the expected byte
	task automatic reg_op(logic wr, logic [7:0] addr, logic [7:0] data, logic [7:0] exp);
		@(negedge clock);
		reg_req = '{addr, wr, !wr, data};
		if (!wr) rq.push_back(exp);
		// Only the two mapped offsets answer with a hit
		hq.push_back(addr == sirq_pkg::ADDR_SOURCE_ENABLE || addr == sirq_pkg::ADDR_PIN_ROUTING);
		@(negedge clock);
		reg_req = '0;
	endtask
	task automatic irq_case(logic [7:0] e, logic [7:0] r, logic [7:0] f, logic pol);
		logic [7:0] p1, p2;
		p1 = f & e & r;
		p2 = f & e & ~r;
		reg_op(1'b1, sirq_pkg::ADDR_SOURCE_ENABLE, e, 8'h00);
		reg_op(1'b1, sirq_pkg::ADDR_PIN_ROUTING, r, 8'h00);
		reg_op(1'b0, sirq_pkg::ADDR_SOURCE_ENABLE, 8'h00, e);
		reg_op(1'b0, sirq_pkg::ADDR_PIN_ROUTING, 8'h00, r);
		@(negedge clock);
		src_flags = f;
		irq_active_high = pol;
		// Pins and host view settle within two edges
		repeat (2) @(negedge clock);
		iq.push_back({|p2, |p1, p1, p2});
		probe = 1'b1;
		@(negedge clock);
		probe = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		rd_d <= reg_req.rd;
		op_d <= reg_req.rd | reg_req.wr;
		pr_d <= probe;
	end
	// Oldest note first; outputs are steady at the falling edge
	always @(negedge clock) begin
		if (rd_d) check("reg_rdata", {10'h000, reg_rdata}, {10'h000, rq.pop_front()});
		if (op_d) check("reg_hit", {17'h00000, reg_hit}, {17'h00000, hq.pop_front()});
		if (pr_d) check("irq", {seen_q, pending_first, pending_second}, iq.pop_front());
	end
	initial begin
		forever #5 clock = ~clock;
	end
	initial begin
		#20000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		// Foreign address must neither store nor answer
		reg_op(1'b1, 8'h52, 8'hFF, 8'h00);
		reg_op(1'b0, sirq_pkg::ADDR_SOURCE_ENABLE, 8'h00, sirq_pkg::RESET_SOURCE_ENABLE);
		reg_op(1'b0, sirq_pkg::ADDR_PIN_ROUTING, 8'h00, sirq_pkg::RESET_PIN_ROUTING);
		reg_op(1'b0, 8'h52, 8'h00, sirq_pkg::READ_UNMAPPED);
		$display("test reset_and_map done");
		irq_case(8'h00, 8'hFF, 8'hFF, 1'b0);
		for (int i = 0; i < 8; i++) irq_case(8'h01 << i, 8'($random(seed)), 8'hFF, i[0]);
		$display("test per_source done");
		for (int i = 0; i < 20; i++) begin
			irq_case(8'($random(seed)), 8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
		end
		$display("test random_mix done");
		repeat (3) @(negedge clock);
		report_and_stop();
	end
endmodule
`default_nettype wire
